// *** design/gpio_level_pkg.sv ***
// Constants for the twelve-pin level register block
//
// Behaviour
// - Pin n level lives in bit n-1 of the level register, pin 1 at bit 0 and pin 12 at bit 11, each defaulting to 0.
// - A write to a level bit drives that pin only while its function select is 0h and its direction is 0.
// - A read of a level bit returns the level sampled from the pin, not the last value written.
// - With polarity 0 the bit and the pin are inverse both ways; with polarity 1 they match.
package gpio_level_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int NUM_PINS   = 12;
   localparam int FN_WIDTH   = 4;
   localparam int DATA_WIDTH = 32;
   localparam int REG_WIDTH  = 16;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   // Level register index; the byte address is four times it
   localparam logic [15:0] IDX_LEVEL    = 16'h400c;
   localparam logic [31:0] ADDR_LEVEL   = {14'h0000, IDX_LEVEL, 2'b00};
   localparam logic [31:0] ADDR_FUNC_LO = 32'h0001_0040;
   localparam logic [31:0] ADDR_FUNC_HI = 32'h0001_0044;
   localparam logic [31:0] ADDR_DIR     = 32'h0001_0048;
   localparam logic [31:0] ADDR_POL     = 32'h0001_004c;

   // ----------------------------------------------------------------
   // Reset values and field codes
   // ----------------------------------------------------------------
   localparam logic [NUM_PINS*FN_WIDTH-1:0] RST_FUNC  = 48'h0000_0000_0000;
   localparam logic [NUM_PINS-1:0]          RST_DIR   = 12'hfff;
   localparam logic [NUM_PINS-1:0]          RST_POL   = 12'hfff;
   localparam logic [FN_WIDTH-1:0]          FN_GPIO   = 4'h0;
   localparam logic                         DIR_OUT   = 1'b0;
   localparam logic                         RST_LEVEL = 1'b0;

endpackage

// *** design/pin_slice_if.sv ***
// Signals between the register block and one pin slice
`timescale 1ns/1ps
interface pin_slice_if;
   logic wr;
   logic wr_bit;
   logic mode;
   logic inv;
   logic pin_in;
   logic rd_bit;
   logic lvl;
   logic pin_out;
   logic pin_oe_n;

   modport slice (
      input  wr, wr_bit, mode, inv, pin_in,
      output rd_bit, lvl, pin_out, pin_oe_n
   );
   modport regs (
      output wr, wr_bit, mode, inv, pin_in,
      input  rd_bit, lvl, pin_out, pin_oe_n
   );
endinterface

// *** design/gpio_pin_slice.sv ***
// One pin: stored output level, input sample and pin drive
`timescale 1ns/1ps
module gpio_pin_slice (
   // Clock and reset
   input  wire logic  i_clk_sys,
   input  wire logic  i_rst_n,
   // Register side
   pin_slice_if.slice ps
);

   logic lvl_q;
   logic in_q;
   logic pin_out_q;
   logic oe_n_q;

   // ----------------------------------------------------------------
   // Stored output level
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         lvl_q <= gpio_level_pkg::RST_LEVEL;
      end else if (ps.wr && ps.mode) begin
         lvl_q <= ps.wr_bit;
      end
   end

   // ----------------------------------------------------------------
   // Pin sampling and drive
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         in_q <= 1'b0;
      end else begin
         in_q <= ps.pin_in;
      end
   end

   // The pin is driven only while it is a plain output; otherwise it floats
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pin_out_q <= 1'b0;
         oe_n_q    <= 1'b1;
      end else begin
         pin_out_q <= lvl_q ^ ps.inv;
         oe_n_q    <= ~ps.mode;
      end
   end

   assign ps.rd_bit   = in_q ^ ps.inv;
   assign ps.lvl      = lvl_q;
   assign ps.pin_out  = pin_out_q;
   assign ps.pin_oe_n = oe_n_q;

endmodule

// *** design/gpio_pin_slice_fix.sv ***
// Level register of the twelve-pin port with its APB slave
`timescale 1ns/1ps
module gpio_level_register (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [31:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Pins
   input  wire logic [11:0] i_pin_in,
   output logic      [11:0] o_pin_out,
   output logic      [11:0] o_pin_oe_n
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   // Configuration held here so the level bits can be gated per pin
   logic [47:0] func_q;
   logic [11:0] dir_q;
   logic [11:0] pol_q;

   // Bus handshake and read path
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rdata_d;
   logic        access;
   logic        done;
   logic        wr_level;

   // Address decode
   logic        hit_level;
   logic        hit_func_lo;
   logic        hit_func_hi;
   logic        hit_dir;
   logic        hit_pol;
   logic        hit_any;

   // Per-pin gathered signals
   logic [11:0] plain_out;
   logic [11:0] rd_bits;
   logic [11:0] lvl_bits;
   logic [11:0] out_bits;
   logic [11:0] oe_n_bits;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   assign hit_level   = (i_paddr == gpio_level_pkg::ADDR_LEVEL);
   assign hit_func_lo = (i_paddr == gpio_level_pkg::ADDR_FUNC_LO);
   assign hit_func_hi = (i_paddr == gpio_level_pkg::ADDR_FUNC_HI);
   assign hit_dir     = (i_paddr == gpio_level_pkg::ADDR_DIR);
   assign hit_pol     = (i_paddr == gpio_level_pkg::ADDR_POL);
   assign hit_any     = hit_level | hit_func_lo | hit_func_hi
                      | hit_dir | hit_pol;

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   // First access cycle: read data is captured here, ready rises next
   assign access   = i_psel & i_penable & ~pready_q;
   // Completing edge: the master samples ready high here
   assign done     = i_psel & i_penable & pready_q;
   assign wr_level = done & i_pwrite & hit_level;

   // One wait state lets read data and ready both come from flops
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= access;
      end
   end

   // Unmapped addresses answer with an error rather than hang
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= access & ~hit_any;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         prdata_q <= 32'h0000_0000;
      end else if (access && !i_pwrite) begin
         prdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (hit_level) begin
         // Pin levels, not stored bits; upper bits stay zero
         rdata_d[11:0] = rd_bits;
      end
      if (hit_func_lo) begin
         rdata_d = func_q[31:0];
      end
      if (hit_func_hi) begin
         rdata_d[15:0] = func_q[47:32];
      end
      if (hit_dir) begin
         rdata_d[11:0] = dir_q;
      end
      if (hit_pol) begin
         rdata_d[11:0] = pol_q;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         func_q <= gpio_level_pkg::RST_FUNC;
      end else begin
         if (done && i_pwrite && hit_func_lo) begin
            func_q[31:0] <= i_pwdata;
         end
         if (done && i_pwrite && hit_func_hi) begin
            func_q[47:32] <= i_pwdata[15:0];
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         dir_q <= gpio_level_pkg::RST_DIR;
      end else if (done && i_pwrite && hit_dir) begin
         dir_q <= i_pwdata[11:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         pol_q <= gpio_level_pkg::RST_POL;
      end else if (done && i_pwrite && hit_pol) begin
         pol_q <= i_pwdata[11:0];
      end
   end

   // ----------------------------------------------------------------
   // Pin slices
   // ----------------------------------------------------------------
   for (genvar n = 0; n < gpio_level_pkg::NUM_PINS; n++) begin : g_pin
      pin_slice_if psi ();

      // Only function 0h with direction 0 makes a plain output
      assign plain_out[n] =
         (func_q[n*gpio_level_pkg::FN_WIDTH +: gpio_level_pkg::FN_WIDTH]
          == gpio_level_pkg::FN_GPIO)
         && (dir_q[n] == gpio_level_pkg::DIR_OUT);

      // Pin n takes bit n-1 of the register, counting pins from one
      assign psi.wr     = wr_level;
      assign psi.wr_bit = i_pwdata[n];
      assign psi.mode   = plain_out[n];
      assign psi.inv    = ~pol_q[n];
      assign psi.pin_in = i_pin_in[n];

      assign rd_bits[n]   = psi.rd_bit;
      assign lvl_bits[n]  = psi.lvl;
      assign out_bits[n]  = psi.pin_out;
      assign oe_n_bits[n] = psi.pin_oe_n;

      gpio_pin_slice u_slice (
         .i_clk_sys (i_clk_sys),
         .i_rst_n   (i_rst_n),
         .ps        (psi)
      );
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_prdata   = prdata_q;
   assign o_pready   = pready_q;
   assign o_pslverr  = pslverr_q;
   assign o_pin_out  = out_bits;
   assign o_pin_oe_n = oe_n_bits;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb_sys @(posedge i_clk_sys);
   endclocking

   default disable iff (!i_rst_n);

   // Ready stands for a single cycle per transfer
   property p_ready_pulse;
      o_pready |=> !o_pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready held longer than one cycle");

   property p_upper_zero;
      o_pready && !i_pwrite && hit_level
         |-> o_prdata[31:12] == 20'h0_0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("unused level bits read nonzero");

   property p_read_level;
      o_pready && !i_pwrite && hit_level
         |-> o_prdata[11:0] == $past(rd_bits);
   endproperty
   a_read_level: assert property (p_read_level)
      else $error("level read does not show sampled pins");

   property p_oe_follow;
      1'b1 |=> o_pin_oe_n == ~$past(plain_out);
   endproperty
   a_oe_follow: assert property (p_oe_follow)
      else $error("pin drive enable disagrees with pin mode");

   property p_pin_polarity;
      1'b1 |=> o_pin_out == $past(lvl_bits ^ ~pol_q);
   endproperty
   a_pin_polarity: assert property (p_pin_polarity)
      else $error("pin output ignores polarity");

   property p_level_write;
      wr_level |=> (lvl_bits & $past(plain_out))
         == ($past(i_pwdata[11:0]) & $past(plain_out));
   endproperty
   a_level_write: assert property (p_level_write)
      else $error("write to plain output not stored");

   property p_level_blocked;
      wr_level |=> (lvl_bits & ~$past(plain_out))
         == $past(lvl_bits & ~plain_out);
   endproperty
   a_level_blocked: assert property (p_level_blocked)
      else $error("write changed a pin that is not a plain output");

   // Main scenarios
   c_level_write: cover property (wr_level && plain_out != 12'h000);
   c_level_read: cover property (o_pready && !i_pwrite && hit_level);
   c_write_blocked: cover property (wr_level && plain_out != 12'hfff);

endmodule

// *** dv/pin_partner.sv ***
// Model of the circuitry on one pin
`timescale 1ns/1ps
module pin_partner (
   // Pin side and external drive
   input  wire logic i_out,
   input  wire logic i_oe_n,
   input  wire logic i_ext,
   // Level seen by the slice
   output wire logic o_pin
);
   assign o_pin = i_oe_n ? i_ext : i_out;
endmodule

// *** dv/gpio_level_register_bench.sv ***
// Testbench for the twelve-pin level register over APB
`timescale 1ns/1ps
module gpio_level_register_bench;
   logic        clk_sys     = 1'b0;
   logic        rst_n       = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [31:0] paddr       = 32'h0000_0000;
   logic [31:0] pwdata      = 32'h0000_0000;
   logic [11:0] ext         = 12'h000;
   logic [31:0] rdata;
   logic        rerr;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire  [11:0] pin;
   wire  [11:0] pin_out;
   wire  [11:0] pin_oe_n;
   int          miscompares = 0;
   int          compares    = 0;
   int          cycles      = 0;

   gpio_level_register uut (
      .i_clk_sys  (clk_sys),
      .i_rst_n    (rst_n),
      .i_psel     (psel),
      .i_penable  (penable),
      .i_pwrite   (pwrite),
      .i_paddr    (paddr),
      .i_pwdata   (pwdata),
      .o_prdata   (prdata),
      .o_pready   (pready),
      .o_pslverr  (pslverr),
      .i_pin_in   (pin),
      .o_pin_out  (pin_out),
      .o_pin_oe_n (pin_oe_n)
   );

   for (genvar n = 0; n < 12; n++) begin : g_far
      pin_partner far (
         .i_out  (pin_out[n]),
         .i_oe_n (pin_oe_n[n]),
         .i_ext  (ext[n]),
         .o_pin  (pin[n])
      );
   end

   always #2.5 clk_sys = ~clk_sys;
   task automatic test_done();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t read data mismatch", $time);
      end
   endtask
   task automatic chk_pins(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t pin state mismatch", $time);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t response flag mismatch", $time);
      end
   endtask
   // Each transfer waits one edge first, so a release and the next
   // setup never fall in the same time step
   task automatic apb_write(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= 1'b1;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic apb_read(input logic [31:0] a, output logic [31:0] d,
                           output logic e);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= a;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      d = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 1000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk_pins(pin_oe_n, 12'hfff);
      apb_read(gpio_level_pkg::ADDR_LEVEL, rdata, rerr);
      chk_data(rdata, 32'h0000_0000);
      ext <= 12'ha5c;
      apb_read(gpio_level_pkg::ADDR_LEVEL, rdata, rerr);
      chk_data(rdata, 32'h0000_0a5c);
      apb_write(gpio_level_pkg::ADDR_POL, 32'h0000_0000);
      apb_read(gpio_level_pkg::ADDR_LEVEL, rdata, rerr);
      chk_data(rdata, 32'h0000_05a3);
      // All pins are inputs: the write must not reach them
      apb_write(gpio_level_pkg::ADDR_LEVEL, 32'hffff_ffff);
      repeat (2) @(posedge clk_sys);
      chk_pins(pin_oe_n, 12'hfff);
      apb_read(gpio_level_pkg::ADDR_LEVEL, rdata, rerr);
      chk_data(rdata, 32'h0000_05a3);
      // Low six pins become plain outputs
      apb_write(gpio_level_pkg::ADDR_DIR, 32'h0000_0fc0);
      apb_write(gpio_level_pkg::ADDR_LEVEL, 32'h0000_002d);
      repeat (2) @(posedge clk_sys);
      chk_pins(pin_oe_n, 12'hfc0);
      chk_pins(pin_out & 12'h03f, 12'h012);
      apb_read(gpio_level_pkg::ADDR_LEVEL, rdata, rerr);
      chk_data(rdata, 32'h0000_05ad);
      // A nonzero function takes pin 1 off the output path
      apb_write(gpio_level_pkg::ADDR_FUNC_LO, 32'h0000_0001);
      repeat (2) @(posedge clk_sys);
      chk_pins(pin_oe_n, 12'hfc1);
      apb_read(32'h0000_0000, rdata, rerr);
      chk_flag(rerr, 1'b1);
      test_done();
   end
endmodule
